//--- rrstes_pkg.sv
`default_nettype none
package rrstes_pkg;
  // ****************************************
  // register map (index, byte address = 4*index)
  // ****************************************
  localparam logic [7:0] IDX_FRAME_STATUS = 8'h13;
  localparam logic [7:0] IDX_TX_FALL = 8'h14;
  localparam logic [7:0] IDX_TX_RISE = 8'h15;
  localparam logic [7:0] IDX_RX_CONFIG = 8'h20;
  localparam logic [7:0] ADDR_FRAME_STATUS = 8'h4c;
  localparam logic [7:0] ADDR_TX_FALL = 8'h50;
  localparam logic [7:0] ADDR_TX_RISE = 8'h54;
  localparam logic [7:0] ADDR_RX_CONFIG = 8'h80;
  // ****************************************
  // field layout and masks
  // ****************************************
  localparam int COLL_POS_LSB = 19;
  localparam int COLL_FLAG_BIT = 18;
  localparam int PROT_ERR_BIT = 17;
  localparam int INTEG_ERR_BIT = 16;
  localparam int LAST_BITS_LSB = 13;
  localparam int FRAMES_LSB = 9;
  localparam int PAT_LSB = 16;
  localparam int LEN_LSB = 1;
  localparam int EN_BIT = 0;
  localparam int ALIGN_LSB = 0;
  localparam int MULTI_BIT = 3;
  localparam int REVPAR_BIT = 4;
  localparam logic [31:0] SHAPE_WMASK = 32'hffff001f;
  localparam logic [31:0] RXCFG_WMASK = 32'h0000001f;
  localparam logic [31:0] RESET_CFG = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {SH_IDLE, SH_FALL, SH_RISE} rrstes_shape_type;
  typedef struct packed {
    logic [6:0] collPos;
    logic collFlag;
    logic protErr;
    logic integErr;
    logic [2:0] lastBits;
    logic [3:0] frames;
    logic [8:0] bytes;
  } rrstes_status_type;
  typedef struct packed {
    logic [31:0] fallCfg;
    logic [31:0] riseCfg;
    logic [31:0] rxCfg;
    rrstes_status_type st;
    logic [6:0] bitCnt;
    logic [8:0] byteCnt;
    logic [3:0] frameCnt;
    logic halted;
    rrstes_shape_type shState;
    logic [15:0] shPat;
    logic [3:0] shLeft;
    logic awGot;
    logic wGot;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } rrstes_state_type;
  typedef struct packed {
    logic start;
    logic bitDone;
    logic byteDone;
    logic frameEnd;
    logic done;
    logic [2:0] lastBits;
    logic collision;
    logic stopErr;
    logic sofEofErr;
    logic countErr;
    logic parityErr;
    logic crcErr;
  } rrstes_rx_event_type;
endpackage
`default_nettype wire

//--- rrstes_regs.sv
// Contract
// [RULE_01] collision position reported in bits 25:19
// [RULE_02] alignment offset added to collision position
// [RULE_03] position valid only in collision-capable modes
// [RULE_04] collision flag bit 18 set on collision
// [RULE_05] protocol error bit 17 on framing faults
// [RULE_06] protocol error stops frame reception
// [RULE_07] both error flags cleared at reception start
// [RULE_08] integrity error bit 16, reception continues
// [RULE_09] reversed parity stop suppresses parity error
// [RULE_10] valid bits of last byte, zero=full
// [RULE_11] frame count updated at receive done
// [RULE_12] byte count held from done until restart
// [RULE_13] falling edge triggers undershoot pattern
// [RULE_14] undershoot length len+1, lsb first
// [RULE_15] undershoot only while its enable set
// [RULE_16] rising edge triggers overshoot pattern
// [RULE_17] overshoot length len+1, msb first
// [RULE_18] overshoot only while its enable set
// [RULE_19] first bit stored at aligned position
// [RULE_20] status writes ignored, reserved read zero
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rrstes_regs (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rrstes_pkg::rrstes_rx_event_type rxEvt,
  input wire logic collCapableMode,
  output logic positionValidIndication,
  output logic rxHalt,
  output logic [2:0] storeBitPos,
  output logic multiFrameEnable,
  input wire logic modFallEdge,
  input wire logic modRiseEdge,
  output logic shapeActive,
  output logic shapeBit
);
  // ****************************************
  // state
  // ****************************************
  rrstes_pkg::rrstes_state_type stateReg;
  rrstes_pkg::rrstes_state_type stateNext;
  logic [2:0] align;
  logic fallEn;
  logic riseEn;
  logic accept;
  logic [6:0] collNow;
  logic [31:0] statusWord;
  logic [31:0] rdWord;
  logic rdHit;
  logic [31:0] wrMerge;

  assign align = stateReg.rxCfg[rrstes_pkg::ALIGN_LSB +: 3];
  assign fallEn = stateReg.fallCfg[rrstes_pkg::EN_BIT];
  assign riseEn = stateReg.riseCfg[rrstes_pkg::EN_BIT];
  assign accept = !stateReg.halted && !rxEvt.start; // RULE_06
  assign collNow = stateReg.bitCnt + {4'h0, align}; // RULE_02
  assign statusWord = {6'h00, stateReg.st}; // RULE_20

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = !stateReg.awGot && !stateReg.bValid;
  assign s_axi_wready = !stateReg.wGot && !stateReg.bValid;
  assign s_axi_bvalid = stateReg.bValid;
  assign s_axi_bresp = stateReg.bResp;
  assign s_axi_arready = !stateReg.rValid;
  assign s_axi_rvalid = stateReg.rValid;
  assign s_axi_rdata = stateReg.rData;
  assign s_axi_rresp = stateReg.rResp;
  assign positionValidIndication = stateReg.st.collFlag && collCapableMode; // RULE_03
  assign rxHalt = stateReg.halted; // RULE_06
  assign storeBitPos = stateReg.bitCnt[2:0] + align; // RULE_19
  assign multiFrameEnable = stateReg.rxCfg[rrstes_pkg::MULTI_BIT];
  assign shapeActive = stateReg.shState != rrstes_pkg::SH_IDLE;
  assign shapeBit = (stateReg.shState == rrstes_pkg::SH_FALL) ? stateReg.shPat[0] :
                    (stateReg.shState == rrstes_pkg::SH_RISE) ? stateReg.shPat[15] : 1'b0;

  // ****************************************
  // read decode
  // ****************************************
  always_comb begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      rrstes_pkg::ADDR_FRAME_STATUS: rdWord = statusWord;
      rrstes_pkg::ADDR_TX_FALL: rdWord = stateReg.fallCfg;
      rrstes_pkg::ADDR_TX_RISE: rdWord = stateReg.riseCfg;
      rrstes_pkg::ADDR_RX_CONFIG: rdWord = stateReg.rxCfg;
      default: begin
        rdWord = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    stateNext = stateReg;
    for (int i = 0; i < 4; i++) begin
      wrMerge[8*i +: 8] = stateReg.wStrb[i] ? stateReg.wData[8*i +: 8] : 8'h00;
    end
    // bus write
    if (s_axi_awvalid && s_axi_awready) begin
      stateNext.awGot = 1'b1;
      stateNext.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      stateNext.wGot = 1'b1;
      stateNext.wData = s_axi_wdata;
      stateNext.wStrb = s_axi_wstrb;
    end
    if (stateReg.awGot && stateReg.wGot && !stateReg.bValid) begin
      stateNext.awGot = 1'b0;
      stateNext.wGot = 1'b0;
      stateNext.bValid = 1'b1;
      stateNext.bResp = rrstes_pkg::RESP_OKAY;
      for (int i = 0; i < 4; i++) begin
        if (stateReg.wStrb[i]) begin
          case (stateReg.awAddr)
            rrstes_pkg::ADDR_TX_FALL: stateNext.fallCfg[8*i +: 8] = wrMerge[8*i +: 8]
              & rrstes_pkg::SHAPE_WMASK[8*i +: 8];
            rrstes_pkg::ADDR_TX_RISE: stateNext.riseCfg[8*i +: 8] = wrMerge[8*i +: 8]
              & rrstes_pkg::SHAPE_WMASK[8*i +: 8];
            rrstes_pkg::ADDR_RX_CONFIG: stateNext.rxCfg[8*i +: 8] = wrMerge[8*i +: 8]
              & rrstes_pkg::RXCFG_WMASK[8*i +: 8];
            default: stateNext.bResp = stateNext.bResp;
          endcase
        end
      end
      if (stateReg.awAddr != rrstes_pkg::ADDR_TX_FALL && stateReg.awAddr != rrstes_pkg::ADDR_TX_RISE
          && stateReg.awAddr != rrstes_pkg::ADDR_RX_CONFIG
          && stateReg.awAddr != rrstes_pkg::ADDR_FRAME_STATUS) begin
        stateNext.bResp = rrstes_pkg::RESP_SLVERR;
      end
    end
    if (stateReg.bValid && s_axi_bready) begin
      stateNext.bValid = 1'b0;
    end
    // bus read
    if (s_axi_arvalid && s_axi_arready) begin
      stateNext.rValid = 1'b1;
      stateNext.rData = rdWord;
      stateNext.rResp = rdHit ? rrstes_pkg::RESP_OKAY : rrstes_pkg::RESP_SLVERR;
    end else if (stateReg.rValid && s_axi_rready) begin
      stateNext.rValid = 1'b0;
    end
    // receive status
    if (rxEvt.start) begin
      stateNext.st.protErr = 1'b0; // RULE_07
      stateNext.st.integErr = 1'b0; // RULE_07
      stateNext.st.collFlag = 1'b0;
      stateNext.st.collPos = 7'h00;
      stateNext.bitCnt = 7'h00;
      stateNext.byteCnt = 9'h000;
      stateNext.frameCnt = 4'h0;
      stateNext.halted = 1'b0;
    end
    if (accept && rxEvt.collision && !stateReg.st.collFlag) begin
      stateNext.st.collFlag = 1'b1; // RULE_04
      stateNext.st.collPos = collNow; // RULE_01
    end
    if (accept && rxEvt.bitDone) begin
      stateNext.bitCnt = stateReg.bitCnt + 7'h01;
    end
    if (accept && rxEvt.byteDone) begin
      stateNext.byteCnt = stateReg.byteCnt + 9'h001;
    end
    if (accept && rxEvt.frameEnd) begin
      stateNext.frameCnt = stateReg.frameCnt + 4'h1;
    end
    if ((!stateReg.halted || rxEvt.start)
        && (rxEvt.stopErr || rxEvt.sofEofErr || rxEvt.countErr)) begin
      stateNext.st.protErr = 1'b1; // RULE_05
      stateNext.halted = 1'b1; // RULE_06
    end
    if ((!stateReg.halted || rxEvt.start) && (rxEvt.crcErr ||
        (rxEvt.parityErr && !stateReg.rxCfg[rrstes_pkg::REVPAR_BIT]))) begin
      stateNext.st.integErr = 1'b1; // RULE_08 RULE_09
    end
    if (rxEvt.done) begin
      stateNext.st.lastBits = rxEvt.lastBits; // RULE_10
      stateNext.st.frames = stateNext.frameCnt; // RULE_11
      stateNext.st.bytes = stateNext.byteCnt; // RULE_12
    end
    // edge shaping sequencer
    if (stateReg.shState != rrstes_pkg::SH_IDLE) begin
      if (stateReg.shLeft == 4'h0) begin
        stateNext.shState = rrstes_pkg::SH_IDLE;
      end else begin
        stateNext.shLeft = stateReg.shLeft - 4'h1;
      end
      case (stateReg.shState)
        rrstes_pkg::SH_FALL: stateNext.shPat = {1'b0, stateReg.shPat[15:1]}; // RULE_14
        rrstes_pkg::SH_RISE: stateNext.shPat = {stateReg.shPat[14:0], 1'b0}; // RULE_17
        default: stateNext.shPat = stateReg.shPat;
      endcase
    end
    if (modFallEdge && fallEn) begin // RULE_15
      stateNext.shState = rrstes_pkg::SH_FALL; // RULE_13
      stateNext.shPat = stateReg.fallCfg[rrstes_pkg::PAT_LSB +: 16];
      stateNext.shLeft = stateReg.fallCfg[rrstes_pkg::LEN_LSB +: 4]; // RULE_14
    end else if (modRiseEdge && riseEn) begin // RULE_18
      stateNext.shState = rrstes_pkg::SH_RISE; // RULE_16
      stateNext.shPat = stateReg.riseCfg[rrstes_pkg::PAT_LSB +: 16];
      stateNext.shLeft = stateReg.riseCfg[rrstes_pkg::LEN_LSB +: 4]; // RULE_17
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stateReg <= '0;
      stateReg.fallCfg <= rrstes_pkg::RESET_CFG;
      stateReg.riseCfg <= rrstes_pkg::RESET_CFG;
      stateReg.shState <= rrstes_pkg::SH_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_coll_flag;
    accept && rxEvt.collision |=> stateReg.st.collFlag;
  endproperty
  a_coll_flag: assert property (p_coll_flag) else $error("collision flag not set"); // RULE_04

  property p_coll_pos;
    accept && rxEvt.collision && !stateReg.st.collFlag |=> stateReg.st.collPos == $past(collNow);
  endproperty
  a_coll_pos: assert property (p_coll_pos) else $error("collision position wrong"); // RULE_02

  property p_coll_keep;
    stateReg.st.collFlag && !rxEvt.start |=> $stable(stateReg.st.collPos);
  endproperty
  a_coll_keep: assert property (p_coll_keep) else $error("first collision overwritten"); // RULE_01

  property p_prot_halt;
    !stateReg.halted && rxEvt.stopErr |=> rxHalt && stateReg.st.protErr;
  endproperty
  a_prot_halt: assert property (p_prot_halt) else $error("protocol error not halting"); // RULE_06

  property p_err_clear;
    rxEvt.start && !rxEvt.stopErr && !rxEvt.sofEofErr && !rxEvt.countErr && !rxEvt.crcErr
      && !rxEvt.parityErr |=> !stateReg.st.protErr && !stateReg.st.integErr;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flags not cleared"); // RULE_07

  property p_rev_parity;
    stateReg.rxCfg[rrstes_pkg::REVPAR_BIT] && !stateReg.st.integErr && !rxEvt.crcErr
      |=> !stateReg.st.integErr;
  endproperty
  a_rev_parity: assert property (p_rev_parity) else $error("parity error not suppressed"); // RULE_09

  property p_bytes;
    rxEvt.done && !rxEvt.start && !rxEvt.byteDone && !stateReg.halted
      |=> stateReg.st.bytes == $past(stateReg.byteCnt);
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte count not latched"); // RULE_12

  property p_fall_bit;
    modFallEdge && fallEn |=> shapeBit == $past(stateReg.fallCfg[rrstes_pkg::PAT_LSB]);
  endproperty
  a_fall_bit: assert property (p_fall_bit) else $error("undershoot not lsb first"); // RULE_14

  property p_rise_bit;
    modRiseEdge && riseEn && !modFallEdge |=> shapeBit == $past(stateReg.riseCfg[31]);
  endproperty
  a_rise_bit: assert property (p_rise_bit) else $error("overshoot not msb first"); // RULE_17

  property p_no_shape;
    !shapeActive && !(modFallEdge && fallEn) && !(modRiseEdge && riseEn) |=> !shapeActive;
  endproperty
  a_no_shape: assert property (p_no_shape) else $error("shaping without enable"); // RULE_15

  property p_prot_other;
    !stateReg.halted && (rxEvt.sofEofErr || rxEvt.countErr) |=> rxHalt && stateReg.st.protErr;
  endproperty
  a_prot_other: assert property (p_prot_other) else $error("framing fault not flagged"); // RULE_05

  property p_halt_ignore;
    stateReg.halted && !rxEvt.start && rxEvt.byteDone |=> stateReg.byteCnt == $past(stateReg.byteCnt);
  endproperty
  a_halt_ignore: assert property (p_halt_ignore) else $error("bytes counted after halt"); // RULE_06

  property p_integ_set;
    !stateReg.halted && rxEvt.crcErr |=> stateReg.st.integErr;
  endproperty
  a_integ_set: assert property (p_integ_set) else $error("integrity error not set"); // RULE_08

  property p_last_bits;
    rxEvt.done |=> stateReg.st.lastBits == $past(rxEvt.lastBits);
  endproperty
  a_last_bits: assert property (p_last_bits) else $error("last bits not latched"); // RULE_10

  property p_frames;
    rxEvt.done && !rxEvt.start && !rxEvt.frameEnd
      |=> stateReg.st.frames == $past(stateReg.frameCnt);
  endproperty
  a_frames: assert property (p_frames) else $error("frame count not latched"); // RULE_11

  property p_rise_off;
    modRiseEdge && !riseEn && !(modFallEdge && fallEn) && !shapeActive |=> !shapeActive;
  endproperty
  a_rise_off: assert property (p_rise_off) else $error("overshoot without enable"); // RULE_18

  property p_shape_end;
    shapeActive && stateReg.shLeft == 4'h0 && !(modFallEdge && fallEn)
      && !(modRiseEdge && riseEn) |=> !shapeActive;
  endproperty
  a_shape_end: assert property (p_shape_end) else $error("pattern too long"); // RULE_14

  property p_fall_next;
    stateReg.shState == rrstes_pkg::SH_FALL && stateReg.shLeft != 4'h0
      && !(modFallEdge && fallEn) && !(modRiseEdge && riseEn)
      |=> shapeBit == $past(stateReg.shPat[1]);
  endproperty
  a_fall_next: assert property (p_fall_next) else $error("undershoot order wrong"); // RULE_14

  c_coll: cover property (accept && rxEvt.collision ##1 positionValidIndication);
  c_fall: cover property (modFallEdge && fallEn ##1 shapeActive [*3]);
  c_write: cover property (stateReg.bValid && s_axi_bready);
  c_rise: cover property (modRiseEdge && riseEn ##1 shapeActive);
  c_prot: cover property (rxEvt.stopErr ##1 rxHalt);
endmodule
`default_nettype wire

//--- rrstes_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rrstes_regs_tb;
  // ****
  // stimulus codes and signals
  // ****
  localparam logic [13:0] E_START = 14'h2000;
  localparam logic [13:0] E_BIT = 14'h1000;
  localparam logic [13:0] E_BYTE = 14'h0800;
  localparam logic [13:0] E_FRAME = 14'h0400;
  localparam logic [13:0] E_DONE = 14'h0200;
  localparam logic [13:0] E_COLL = 14'h0020;
  localparam logic [13:0] E_PAR = 14'h0002;
  localparam logic [13:0] E_CRC = 14'h0001;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [1:0] OK = rrstes_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = rrstes_pkg::RESP_SLVERR;
  localparam logic [7:0] A_ST = rrstes_pkg::ADDR_FRAME_STATUS;
  localparam logic [7:0] A_FALL = rrstes_pkg::ADDR_TX_FALL;
  localparam logic [7:0] A_RISE = rrstes_pkg::ADDR_TX_RISE;
  localparam logic [7:0] A_CFG = rrstes_pkg::ADDR_RX_CONFIG;
  logic mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, collCapableMode, positionValidIndication, rxHalt;
  logic multiFrameEnable, modFallEdge, modRiseEdge, shapeActive, shapeBit;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] storeBitPos;
  rrstes_pkg::rrstes_rx_event_type rxEvt;
  int checks, nFail;

  rrstes_regs dut (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rxEvt(rxEvt), .collCapableMode(collCapableMode),
    .positionValidIndication(positionValidIndication), .rxHalt(rxHalt),
    .storeBitPos(storeBitPos), .multiFrameEnable(multiFrameEnable), .modFallEdge(modFallEdge),
    .modRiseEdge(modRiseEdge), .shapeActive(shapeActive), .shapeBit(shapeBit));

  // ****
  // helpers
  // ****
  task chkWord(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chkBit(input logic got, input logic exp);
    chkWord({31'h0, got}, {31'h0, exp});
  endtask
  task wrChk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic tA, tW, tB;
    logic [1:0] r;
    int n;
    tB = 1'h0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tB && n < 100) begin
      @(negedge mclk);
      n++;
      tA = awvalid && awready;
      tW = wvalid && wready;
      tB = bvalid && bready;
      r = bresp;
      @(posedge mclk);
      if (tA) awvalid <= 1'h0;
      if (tW) wvalid <= 1'h0;
      if (tB) bready <= 1'h0;
    end
    chkWord({30'h0, r}, {30'h0, er});
    @(posedge mclk);
  endtask
  task rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
             input logic [1:0] er);
    logic tA, tR;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    tR = 1'h0;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tR && n < 100) begin
      @(negedge mclk);
      n++;
      tA = arvalid && arready;
      tR = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (tA) arvalid <= 1'h0;
      if (tR) rready <= 1'h0;
    end
    chkWord(d & m, exp);
    chkWord({30'h0, r}, {30'h0, er});
    @(posedge mclk);
  endtask
  task pulse(input logic [13:0] v);
    rxEvt <= rrstes_pkg::rrstes_rx_event_type'(v);
    @(posedge mclk);
  endtask
  task shape(input logic rise, input logic [15:0] p, input logic [3:0] len);
    int i;
    if (rise) modRiseEdge <= 1'h1;
    else modFallEdge <= 1'h1;
    @(posedge mclk);
    modRiseEdge <= 1'h0;
    modFallEdge <= 1'h0;
    for (i = 0; i <= len; i++) begin
      @(negedge mclk);
      chkBit(shapeActive, 1'h1);
      chkBit(shapeBit, rise ? p[15-i] : p[i]);
      @(posedge mclk);
    end
    @(negedge mclk);
    chkBit(shapeActive, 1'h0);
    @(posedge mclk);
  endtask
  task printVerdict();
    $display("checks=%0d nFail=%0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ****
  // scenarios
  // ****
  task busMap();
    rdChk(A_ST, 32'h0, ALL, OK);
    rdChk(A_CFG, 32'h0, ALL, OK);
    wrChk(8'h58, ALL, ERR);
    rdChk(8'h58, 32'h0, ALL, ERR);
    wrChk(A_FALL, ALL, OK);
    rdChk(A_FALL, 32'hffff001f, ALL, OK);
    wrChk(A_RISE, ALL, OK);
    rdChk(A_RISE, 32'hffff001f, ALL, OK);
  endtask
  task shaping();
    wrChk(A_FALL, 32'ha5c30005, OK);
    wrChk(A_RISE, 32'h9a35001f, OK);
    shape(1'h0, 16'ha5c3, 4'h2);
    shape(1'h1, 16'h9a35, 4'hf);
    wrChk(A_FALL, 32'ha5c30004, OK);
    wrChk(A_RISE, 32'h9a35001e, OK);
    modFallEdge <= 1'h1;
    modRiseEdge <= 1'h1;
    @(posedge mclk);
    modFallEdge <= 1'h0;
    modRiseEdge <= 1'h0;
    repeat (3) begin
      @(negedge mclk);
      chkBit(shapeActive, 1'h0);
      @(posedge mclk);
    end
  endtask
  task rxFrame();
    wrChk(A_CFG, 32'h0000000b, OK);
    pulse(E_START);
    repeat (2) pulse(E_BIT);
    pulse(14'h0);
    @(negedge mclk);
    chkWord({29'h0, storeBitPos}, 32'h5);
    chkBit(multiFrameEnable, 1'h1);
    @(posedge mclk);
    repeat (3) pulse(E_BIT);
    pulse(E_COLL);
    pulse(E_PAR);
    pulse(E_BYTE);
    pulse(E_BIT);
    pulse(E_COLL);
    pulse(E_BYTE);
    pulse(E_FRAME);
    pulse(E_BYTE);
    pulse(E_FRAME);
    pulse(E_DONE | 14'h0140);
    pulse(14'h0);
    @(negedge mclk);
    chkBit(positionValidIndication, 1'h1);
    @(posedge mclk);
    collCapableMode <= 1'h0;
    @(negedge mclk);
    chkBit(positionValidIndication, 1'h0);
    @(posedge mclk);
    rdChk(A_ST, 32'h0045a403, ALL, OK);
    wrChk(A_ST, ALL, OK);
    rdChk(A_ST, 32'h0045a403, ALL, OK);
  endtask
  task protoErrs();
    logic [13:0] errs [3];
    int i;
    errs = '{14'h0010, 14'h0008, 14'h0004};
    for (i = 0; i < 3; i++) begin
      pulse(E_START);
      pulse(14'h0);
      rdChk(A_ST, 32'h0, 32'h00070000, OK);
      pulse(E_BYTE);
      pulse(errs[i]);
      pulse(14'h0);
      @(negedge mclk);
      chkBit(rxHalt, 1'h1);
      @(posedge mclk);
      repeat (2) pulse(E_BYTE);
      pulse(E_DONE);
      pulse(14'h0);
      rdChk(A_ST, 32'h00020001, 32'h0007ffff, OK);
    end
  endtask
  task revParity();
    wrChk(A_CFG, 32'h00000010, OK);
    pulse(E_START);
    pulse(E_PAR);
    pulse(14'h0);
    rdChk(A_ST, 32'h0, 32'h00010000, OK);
    pulse(E_CRC);
    pulse(14'h0);
    rdChk(A_ST, 32'h00010000, 32'h00010000, OK);
  endtask

  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    nFail++;
    printVerdict();
  end
  initial begin
    rstn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, modFallEdge, modRiseEdge} = 7'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    collCapableMode = 1'h1;
    rxEvt = '0;
    checks = 0;
    nFail = 0;
    repeat (5) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    busMap();
    shaping();
    rxFrame();
    protoErrs();
    revParity();
    printVerdict();
  end
endmodule
`default_nettype wire
